// [rtl/mel_error_log_bank.sv]
// Memory error log bank: four status/detail register pairs and the
// extra logging control register, reached by register read/write.
// Assumes error reports and register accesses come from logic on clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "mel_regs.svh"

// Summary of operation
// [R1] Log controller errors in banks eight to eleven
// [R2] Status 15:0 holds 1MMMCCCC memory class code
// [R3] Control bit one enables extra detail logging
// [R4] Model field codes address, buffer, enable parity
// [R5] Model field codes scrub and spare errors
// [R6] Extra: first failing device id in 36:32
// [R7] Detail 13:9: second device or parity info
// [R8] Extra: device bit masks in 29:14, 45:30
// [R9] Extra: failing ranks in 50:46, 55:51
// [R10] Extra: bit 62 marks first device valid
// [R11] Extra: bit 63 marks second device valid
// [R12] Reader trusts second device after bit 62
// [R13] Reserved bits read zero; 63:57 validity flags
module mel_error_log_bank
    import mel_pkg::*;
(
    input wire logic clk_i,              // Core clock
    input wire logic rst_n_i,            // Async reset, active low
    input wire logic msr_wr_i,           // Register write strobe
    input wire logic msr_rd_i,           // Register read strobe
    input wire logic [5:0] msr_addr_i,   // Register address
    input wire logic [63:0] msr_wdata_i, // Write data
    output logic [63:0] msr_rdata_o,     // Read data, registered
    output logic msr_rvalid_o,           // Read data valid pulse
    output logic msr_fault_o,            // Unmapped access pulse
    input wire logic err_valid_i,        // Error report pulse
    input wire logic [1:0] err_bank_i,   // Target bank, 0 is bank 8
    input wire mel_err_kind_t err_kind_i, // Error kind
    input wire logic [2:0] err_txn_i,    // Transaction type
    input wire logic [3:0] err_chan_i,   // Channel
    input wire logic [8:0] err_addr_info_i, // Address information
    input wire logic [4:0] err_par_detail_i, // Parity detail
    input wire logic [4:0] err_dev1_id_i, // First failing device
    input wire logic [15:0] err_dev1_mask_i, // First device mask
    input wire logic [4:0] err_dev1_rank_i, // First device rank
    input wire logic err_dev2_present_i, // Second device offered
    input wire logic [4:0] err_dev2_id_i, // Second failing device
    input wire logic [15:0] err_dev2_mask_i, // Second device mask
    input wire logic [4:0] err_dev2_rank_i, // Second device rank
    output logic extra_logging_o,        // Extra logging enabled
    output logic [3:0] bank_valid_o      // Status valid per bank
);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic mel_dec_t decode(input logic [5:0] a);
        logic [3:0] num;
        num = a[5:2];
        decode = '0;
        if (a == `MEL_ADDR_CTRL) begin
            decode.hit = 1'b1;
            decode.is_ctrl = 1'b1;
        end else if (num >= `MEL_BANK_FIRST && num <= `MEL_BANK_LAST &&
                     (a[1:0] == `MEL_KIND_STATUS ||
                      a[1:0] == `MEL_KIND_MISC)) begin // [R1]
            decode.hit = 1'b1;
            decode.is_misc = (a[1:0] == `MEL_KIND_MISC);
            decode.bank = 2'(num - `MEL_BANK_FIRST);
        end
    endfunction

    mel_state_t s_q;
    mel_state_t s_d;
    mel_dec_t wdec;
    mel_dec_t rdec;
    logic [63:0] base_status;
    logic [63:0] base_misc;
    logic [63:0] cap_status;
    logic [63:0] cap_misc;
    logic wr_st_hit;
    logic wr_mi_hit;

    // ------------------------------------------------------------
    // Value the event merges into, after any same-cycle write
    // ------------------------------------------------------------
    // Feeding the written value in lets the hardware event win over a
    // software clear in the same cycle.
    assign wdec = decode(msr_addr_i);
    assign rdec = decode(msr_addr_i);
    assign wr_st_hit = msr_wr_i && wdec.hit && !wdec.is_ctrl &&
                       !wdec.is_misc && wdec.bank == err_bank_i;
    assign wr_mi_hit = msr_wr_i && wdec.hit && !wdec.is_ctrl &&
                       wdec.is_misc && wdec.bank == err_bank_i;
    assign base_status = wr_st_hit ? (msr_wdata_i & `MEL_ST_WMASK)
                                   : s_q.status[err_bank_i];
    assign base_misc = wr_mi_hit ? (msr_wdata_i & `MEL_MI_WMASK)
                                 : s_q.misc[err_bank_i];

    // ------------------------------------------------------------
    // Event merge
    // ------------------------------------------------------------
    mel_capture u_capture (
        .kind_i(err_kind_i),
        .txn_i(err_txn_i),
        .chan_i(err_chan_i),
        .addr_info_i(err_addr_info_i),
        .par_detail_i(err_par_detail_i),
        .dev1_id_i(err_dev1_id_i),
        .dev1_mask_i(err_dev1_mask_i),
        .dev1_rank_i(err_dev1_rank_i),
        .dev2_present_i(err_dev2_present_i),
        .dev2_id_i(err_dev2_id_i),
        .dev2_mask_i(err_dev2_mask_i),
        .dev2_rank_i(err_dev2_rank_i),
        .extra_i(s_q.ctrl[`MEL_CTRL_EXTRA_BIT]), // [R3]
        .status_i(base_status),
        .misc_i(base_misc),
        .status_o(cap_status),
        .misc_o(cap_misc)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.rvalid = 1'b0;
        s_d.fault = 1'b0;
        // Software writes; reserved bits are masked off
        if (msr_wr_i) begin
            if (!wdec.hit) begin
                s_d.fault = 1'b1;
            end else if (wdec.is_ctrl) begin
                s_d.ctrl = msr_wdata_i & `MEL_CTRL_MASK; // [R3]
            end else if (wdec.is_misc) begin
                s_d.misc[wdec.bank] = msr_wdata_i & `MEL_MI_WMASK; // [R13]
            end else begin
                s_d.status[wdec.bank] = msr_wdata_i & `MEL_ST_WMASK; // [R13]
            end
        end
        // Error report lands last, so it overrides a same-cycle write
        if (err_valid_i) begin
            s_d.status[err_bank_i] = cap_status; // [R1]
            s_d.misc[err_bank_i] = cap_misc;
        end
        // Reads return the value held before this cycle's updates
        if (msr_rd_i) begin
            s_d.rvalid = 1'b1;
            s_d.rdata = '0;
            if (!rdec.hit) begin
                s_d.fault = 1'b1;
            end else if (rdec.is_ctrl) begin
                s_d.rdata = s_q.ctrl;
            end else if (rdec.is_misc) begin
                s_d.rdata = s_q.misc[rdec.bank];
            end else begin
                s_d.rdata = s_q.status[rdec.bank];
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q.ctrl <= `MEL_CTRL_RESET;
            s_q.status <= {`MEL_BANKS{`MEL_ST_RESET}};
            s_q.misc <= {`MEL_BANKS{`MEL_MI_RESET}};
            s_q.rdata <= 64'h0000_0000_0000_0000;
            s_q.rvalid <= 1'b0;
            s_q.fault <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign msr_rdata_o = s_q.rdata;
    assign msr_rvalid_o = s_q.rvalid;
    assign msr_fault_o = s_q.fault;
    assign extra_logging_o = s_q.ctrl[`MEL_CTRL_EXTRA_BIT];
    always_comb begin
        for (int b = 0; b < `MEL_BANKS; b++) begin
            bank_valid_o[b] = s_q.status[b][`MEL_ST_VAL];
        end
    end

endmodule
`default_nettype wire

// [rtl/mel_regs.svh]
// Constants of the memory error log bank: addresses, field positions,
// write masks, reset values and model-specific error codes.
// Assumes the includer needs only `define macros, no types.
`ifndef MEL_REGS_SVH
`define MEL_REGS_SVH

// ----------------------------------------------------------------
// Register addressing: {bank number[3:0], register kind[1:0]}
// ----------------------------------------------------------------
`define MEL_ADDR_W 6
`define MEL_BANK_FIRST 4'h8
`define MEL_BANK_LAST 4'hB
`define MEL_BANKS 4
`define MEL_KIND_STATUS 2'h1
`define MEL_KIND_MISC 2'h3
`define MEL_ADDR_CTRL 6'h3C

// ----------------------------------------------------------------
// Extra logging control register
// ----------------------------------------------------------------
`define MEL_CTRL_EXTRA_BIT 1
`define MEL_CTRL_MASK 64'h0000_0000_0000_0002
`define MEL_CTRL_RESET 64'h0000_0000_0000_0000

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define MEL_ST_CODE_MSB 15
`define MEL_ST_CODE_LSB 0
`define MEL_ST_MODEL_MSB 31
`define MEL_ST_MODEL_LSB 16
`define MEL_ST_DEV1_MSB 36
`define MEL_ST_DEV1_LSB 32
`define MEL_ST_CNT_MSB 52
`define MEL_ST_CNT_LSB 38
`define MEL_ST_PCC 57
`define MEL_ST_ADDRV 58
`define MEL_ST_MISCV 59
`define MEL_ST_EN 60
`define MEL_ST_UC 61
`define MEL_ST_OVER 62
`define MEL_ST_VAL 63
`define MEL_ST_WMASK 64'hFFFF_FFDF_FFFF_FFFF
`define MEL_ST_RESET 64'h0000_0000_0000_0000

// ----------------------------------------------------------------
// Detail (miscellaneous) register fields
// ----------------------------------------------------------------
`define MEL_MI_ADDR_MSB 8
`define MEL_MI_ADDR_LSB 0
`define MEL_MI_DEV2_MSB 13
`define MEL_MI_DEV2_LSB 9
`define MEL_MI_MASK1_MSB 29
`define MEL_MI_MASK1_LSB 14
`define MEL_MI_MASK2_MSB 45
`define MEL_MI_MASK2_LSB 30
`define MEL_MI_RANK1_MSB 50
`define MEL_MI_RANK1_LSB 46
`define MEL_MI_RANK2_MSB 55
`define MEL_MI_RANK2_LSB 51
`define MEL_MI_V1 62
`define MEL_MI_V2 63
`define MEL_MI_WMASK 64'hC0FF_FFFF_FFFF_FFFF
`define MEL_MI_RESET 64'h0000_0000_0000_0000

// ----------------------------------------------------------------
// Model-specific error codes, status bits 31:16
// ----------------------------------------------------------------
`define MEL_MC_ADDR_PAR 16'h0001
`define MEL_MC_WB_DATA_PAR 16'h0002
`define MEL_MC_WBE_PAR 16'h0004
`define MEL_MC_SCRUB_CE 16'h0008
`define MEL_MC_SCRUB_UCE 16'h0010
`define MEL_MC_SPARE_CE 16'h0020
`define MEL_MC_SPARE_UCE 16'h0040
`define MEL_MC_NONE 16'h0000
`define MEL_CNT_MAX 15'h7FFF

`endif

// [rtl/mel_pkg.sv]
// Types shared by the memory error log bank modules.
// Assumes mel_regs.svh is on the include path.
`include "mel_regs.svh"

package mel_pkg;

    // Kind of error reported by the memory controller unit
    typedef enum logic [2:0] {
        MEL_ERR_ADDR_PAR = 3'h0,
        MEL_ERR_WB_DATA_PAR = 3'h1,
        MEL_ERR_WBE_PAR = 3'h2,
        MEL_ERR_SCRUB_CE = 3'h3,
        MEL_ERR_SCRUB_UCE = 3'h4,
        MEL_ERR_SPARE_CE = 3'h5,
        MEL_ERR_SPARE_UCE = 3'h6,
        MEL_ERR_READ_CE = 3'h7
    } mel_err_kind_t;

    // Result of decoding a register address
    typedef struct packed {
        logic hit;
        logic is_ctrl;
        logic is_misc;
        logic [1:0] bank;
    } mel_dec_t;

    // Whole state of the register bank
    typedef struct packed {
        logic [63:0] ctrl;
        logic [`MEL_BANKS-1:0][63:0] status;
        logic [`MEL_BANKS-1:0][63:0] misc;
        logic [63:0] rdata;
        logic rvalid;
        logic fault;
    } mel_state_t;

endpackage

// [rtl/mel_capture.sv]
// Merges one reported memory error into a bank's status and detail words.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
`include "mel_regs.svh"

module mel_capture
    import mel_pkg::*;
(
    input wire mel_err_kind_t kind_i,  // Error kind
    input wire logic [2:0] txn_i,      // Transaction type MMM
    input wire logic [3:0] chan_i,     // Channel CCCC
    input wire logic [8:0] addr_info_i, // Address information
    input wire logic [4:0] par_detail_i, // Parity error detail
    input wire logic [4:0] dev1_id_i,  // First failing device
    input wire logic [15:0] dev1_mask_i, // First device bit mask
    input wire logic [4:0] dev1_rank_i, // First device rank
    input wire logic dev2_present_i,   // Second device info offered
    input wire logic [4:0] dev2_id_i,  // Second failing device
    input wire logic [15:0] dev2_mask_i, // Second device bit mask
    input wire logic [4:0] dev2_rank_i, // Second device rank
    input wire logic extra_i,          // Extra logging enabled
    input wire logic [63:0] status_i,  // Status before the event
    input wire logic [63:0] misc_i,    // Detail before the event
    output logic [63:0] status_o,      // Status after the event
    output logic [63:0] misc_o         // Detail after the event
);

    // ------------------------------------------------------------
    // Code tables
    // ------------------------------------------------------------
    function automatic logic [15:0] model_code(input mel_err_kind_t k);
        case (k)
            MEL_ERR_ADDR_PAR: model_code = `MEL_MC_ADDR_PAR;
            MEL_ERR_WB_DATA_PAR: model_code = `MEL_MC_WB_DATA_PAR;
            MEL_ERR_WBE_PAR: model_code = `MEL_MC_WBE_PAR;
            MEL_ERR_SCRUB_CE: model_code = `MEL_MC_SCRUB_CE;
            MEL_ERR_SCRUB_UCE: model_code = `MEL_MC_SCRUB_UCE;
            MEL_ERR_SPARE_CE: model_code = `MEL_MC_SPARE_CE;
            MEL_ERR_SPARE_UCE: model_code = `MEL_MC_SPARE_UCE;
            default: model_code = `MEL_MC_NONE;
        endcase
    endfunction

    function automatic logic is_corrected(input mel_err_kind_t k);
        is_corrected = (k == MEL_ERR_SCRUB_CE) || (k == MEL_ERR_SPARE_CE) ||
                       (k == MEL_ERR_READ_CE);
    endfunction

    logic uc;
    logic take;
    logic [14:0] cnt;
    logic v1_now;

    // ------------------------------------------------------------
    // Merge
    // ------------------------------------------------------------
    // An uncorrected error displaces a corrected one; otherwise the
    // first error stays and later ones only raise overflow, bump the count if corrected, and, as extra-logged corrected reads, fill free device slots.
    always_comb begin
        status_o = status_i;
        misc_o = misc_i;
        uc = !is_corrected(kind_i);
        take = !status_i[`MEL_ST_VAL] || (uc && !status_i[`MEL_ST_UC]);
        cnt = status_i[`MEL_ST_CNT_MSB:`MEL_ST_CNT_LSB];
        v1_now = misc_i[`MEL_MI_V1];
        if (status_i[`MEL_ST_VAL]) begin
            status_o[`MEL_ST_OVER] = 1'b1;
        end
        if (!uc && cnt != `MEL_CNT_MAX) begin
            status_o[`MEL_ST_CNT_MSB:`MEL_ST_CNT_LSB] = cnt + 15'h0001;
        end
        if (take) begin
            status_o[`MEL_ST_CODE_MSB:`MEL_ST_CODE_LSB] =
                {8'h00, 1'b1, txn_i, chan_i}; // [R2]
            status_o[`MEL_ST_MODEL_MSB:`MEL_ST_MODEL_LSB] =
                model_code(kind_i); // [R4] [R5]
            status_o[`MEL_ST_VAL] = 1'b1; // [R13]
            status_o[`MEL_ST_UC] = uc;
            status_o[`MEL_ST_EN] = 1'b1;
            status_o[`MEL_ST_MISCV] = 1'b1;
            misc_o[`MEL_MI_ADDR_MSB:`MEL_MI_ADDR_LSB] = addr_info_i;
            // Parity detail only while extra logging does not own it
            if (!extra_i && (kind_i == MEL_ERR_WB_DATA_PAR ||
                             kind_i == MEL_ERR_WBE_PAR)) begin
                misc_o[`MEL_MI_DEV2_MSB:`MEL_MI_DEV2_LSB] = par_detail_i; // [R7]
            end
        end
        // Device detail of corrected normal reads, first one kept
        if (extra_i && kind_i == MEL_ERR_READ_CE) begin // [R3]
            if (!v1_now) begin
                status_o[`MEL_ST_DEV1_MSB:`MEL_ST_DEV1_LSB] = dev1_id_i; // [R6]
                misc_o[`MEL_MI_MASK1_MSB:`MEL_MI_MASK1_LSB] = dev1_mask_i; // [R8]
                misc_o[`MEL_MI_RANK1_MSB:`MEL_MI_RANK1_LSB] = dev1_rank_i; // [R9]
                misc_o[`MEL_MI_V1] = 1'b1; // [R10]
                v1_now = 1'b1;
            end
            // Second device only rides on valid first-device data
            if (dev2_present_i && v1_now && !misc_i[`MEL_MI_V2]) begin // [R12]
                misc_o[`MEL_MI_DEV2_MSB:`MEL_MI_DEV2_LSB] = dev2_id_i; // [R7]
                misc_o[`MEL_MI_MASK2_MSB:`MEL_MI_MASK2_LSB] = dev2_mask_i; // [R8]
                misc_o[`MEL_MI_RANK2_MSB:`MEL_MI_RANK2_LSB] = dev2_rank_i; // [R9]
                misc_o[`MEL_MI_V2] = 1'b1; // [R11]
            end
        end
    end

endmodule
`default_nettype wire

// [sim/mel_error_log_bank_sva.sv]
// Checker for the register port and log flags of the error log bank.
// Assumes mel_pkg is compiled first; bound to the bank module below.
`timescale 1ns/1ps
`default_nettype none

module mel_error_log_bank_sva
    import mel_pkg::*;
(
    input wire logic clk_i,              // Core clock
    input wire logic rst_n_i,            // Reset, active low
    input wire logic msr_wr_i,           // Write strobe
    input wire logic msr_rd_i,           // Read strobe
    input wire logic [5:0] msr_addr_i,   // Register address
    input wire logic [63:0] msr_wdata_i, // Write data
    input wire logic [63:0] msr_rdata_o, // Read data
    input wire logic msr_rvalid_o,       // Read valid pulse
    input wire logic msr_fault_o,        // Unmapped access pulse
    input wire logic err_valid_i,        // Error report
    input wire logic [1:0] err_bank_i,   // Target bank
    input wire logic extra_logging_o,    // Extra logging level
    input wire logic [3:0] bank_valid_o  // Status valid per bank
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // ----------------------------------------------------------------
    // Address decode, kept apart from the design's own decoder
    // ----------------------------------------------------------------
    logic mapped;
    logic acc;
    logic ctrl;
    assign ctrl = (msr_addr_i == 6'h3C);
    assign mapped = ctrl || (msr_addr_i[5:4] == 2'b10 && msr_addr_i[0]);
    assign acc = msr_rd_i || msr_wr_i;

    // ----------------------------------------------------------------
    // Register port timing and decode
    // ----------------------------------------------------------------
    sequence s_read;
        msr_rd_i ##1 msr_rvalid_o;
    endsequence
    property p_rd_answer; msr_rd_i |-> s_read; endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read not answered one cycle later");
    property p_rv_pulse; !msr_rd_i |=> !msr_rvalid_o; endproperty
    a_rv_pulse: assert property (p_rv_pulse)
        else $error("read valid without a read");
    property p_fault; acc && !mapped |=> msr_fault_o; endproperty
    a_fault: assert property (p_fault)
        else $error("unmapped access without fault");
    property p_no_fault; !(acc && !mapped) |=> !msr_fault_o; endproperty
    a_no_fault: assert property (p_no_fault)
        else $error("fault on a mapped access");

    // ----------------------------------------------------------------
    // Extra logging control
    // ----------------------------------------------------------------
    property p_ctrl_wr;
        msr_wr_i && ctrl |=> extra_logging_o == $past(msr_wdata_i[1]);
    endproperty
    a_ctrl_wr: assert property (p_ctrl_wr)
        else $error("control bit not taken from write");
    property p_extra_hold;
        !(msr_wr_i && ctrl) |=> $stable(extra_logging_o);
    endproperty
    a_extra_hold: assert property (p_extra_hold)
        else $error("extra logging moved without a write");
    property p_ctrl_rd;
        msr_rd_i && ctrl |=>
            msr_rdata_o == {62'h0, $past(extra_logging_o), 1'b0};
    endproperty
    a_ctrl_rd: assert property (p_ctrl_rd)
        else $error("control read shows more than bit one");

    // ----------------------------------------------------------------
    // Log validity and reserved bits
    // ----------------------------------------------------------------
    property p_log_valid;
        err_valid_i |=> bank_valid_o[$past(err_bank_i)];
    endproperty
    a_log_valid: assert property (p_log_valid)
        else $error("reported error left bank invalid");
    property p_valid_hold;
        !err_valid_i && !msr_wr_i |=> $stable(bank_valid_o);
    endproperty
    a_valid_hold: assert property (p_valid_hold)
        else $error("bank valid moved with no cause");
    property p_st_resv;
        msr_rd_i && mapped && !msr_addr_i[1] |=> !msr_rdata_o[37];
    endproperty
    a_st_resv: assert property (p_st_resv)
        else $error("status reserved bit read as one");
    property p_mi_resv;
        msr_rd_i && mapped && msr_addr_i[1] |=> msr_rdata_o[61:56] == 6'h0;
    endproperty
    a_mi_resv: assert property (p_mi_resv)
        else $error("detail reserved bits read non zero");
endmodule

bind mel_error_log_bank mel_error_log_bank_sva u_sva (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .msr_wr_i(msr_wr_i),
    .msr_rd_i(msr_rd_i), .msr_addr_i(msr_addr_i),
    .msr_wdata_i(msr_wdata_i), .msr_rdata_o(msr_rdata_o),
    .msr_rvalid_o(msr_rvalid_o), .msr_fault_o(msr_fault_o),
    .err_valid_i(err_valid_i), .err_bank_i(err_bank_i),
    .extra_logging_o(extra_logging_o), .bank_valid_o(bank_valid_o)
);
`default_nettype wire

// [sim/mel_error_log_bank_tb.sv]
// Self-checking bench for the memory error log bank.
// Assumes the rtl files and the checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none

module mel_error_log_bank_tb import mel_pkg::*;;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic msr_wr_i = 1'b0;
    logic msr_rd_i = 1'b0;
    logic [5:0] msr_addr_i = 6'h0;
    logic [63:0] msr_wdata_i = 64'h0;
    logic [63:0] msr_rdata_o;
    logic msr_rvalid_o, msr_fault_o, extra_logging_o;
    logic err_valid_i = 1'b0;
    logic err_dev2_present_i = 1'b0;
    logic [1:0] err_bank_i = 2'h0;
    mel_err_kind_t err_kind_i = MEL_ERR_ADDR_PAR;
    logic [2:0] err_txn_i = 3'h0;
    logic [3:0] err_chan_i = 4'h0;
    logic [8:0] err_addr_info_i = 9'h1A5;
    logic [4:0] err_par_detail_i = 5'h13;
    logic [4:0] err_dev1_id_i = 5'h0B;
    logic [3:0] bank_valid_o;
    int errors = 0;
    int check_count = 0;
    logic [63:0] mi;

    // 40 MHz clock
    always #12.5 clk_i = ~clk_i;

    mel_error_log_bank dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .msr_wr_i(msr_wr_i),
        .msr_rd_i(msr_rd_i), .msr_addr_i(msr_addr_i),
        .msr_wdata_i(msr_wdata_i), .msr_rdata_o(msr_rdata_o),
        .msr_rvalid_o(msr_rvalid_o), .msr_fault_o(msr_fault_o),
        .err_valid_i(err_valid_i), .err_bank_i(err_bank_i),
        .err_kind_i(err_kind_i), .err_txn_i(err_txn_i),
        .err_chan_i(err_chan_i), .err_addr_info_i(err_addr_info_i),
        .err_par_detail_i(err_par_detail_i),
        .err_dev1_id_i(err_dev1_id_i),
        .err_dev1_mask_i(16'hA5C3), .err_dev1_rank_i(5'h07),
        .err_dev2_present_i(err_dev2_present_i), .err_dev2_id_i(5'h16),
        .err_dev2_mask_i(16'h3C5A), .err_dev2_rank_i(5'h19),
        .extra_logging_o(extra_logging_o), .bank_valid_o(bank_valid_o)
    );

    // ----------------------------------------------------------------
    // Access tasks; an idle edge first, so no strobe glitches low-high
    // ----------------------------------------------------------------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [63:0] d);
        @(posedge clk_i);
        #1;
        msr_wr_i = 1'b1;
        msr_addr_i = a;
        msr_wdata_i = d;
        @(posedge clk_i);
        #1;
        msr_wr_i = 1'b0;
    endtask

    task automatic rd(input logic [5:0] a, input logic [63:0] exp,
                      input logic flt);
        @(posedge clk_i);
        #1;
        msr_rd_i = 1'b1;
        msr_addr_i = a;
        @(posedge clk_i);
        #1;
        msr_rd_i = 1'b0;
        chk({63'h0, msr_rvalid_o}, 64'h1);
        chk({63'h0, msr_fault_o}, {63'h0, flt});
        chk(msr_rdata_o, exp);
    endtask

    // Channel is derived from the kind so each code differs
    task automatic err(input logic [1:0] b, input logic [2:0] k,
                       input logic p);
        @(posedge clk_i);
        #1;
        err_valid_i = 1'b1;
        err_bank_i = b;
        err_kind_i = mel_err_kind_t'(k);
        err_txn_i = k;
        err_chan_i = 4'hF - {1'b0, k};
        err_dev2_present_i = p;
        @(posedge clk_i);
        #1;
        err_valid_i = 1'b0;
    endtask

    // Expected status: flags, count, device id, model code, class code
    function automatic logic [63:0] st_exp(input logic [2:0] k,
        input logic [14:0] cnt, input logic ov, input logic [4:0] dev);
        logic uc;
        logic [15:0] model;
        uc = (k inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h6});
        model = (k == 3'h7) ? 16'h0 : 16'h1 << k;
        return {1'b1, ov, uc, 2'b11, 6'h0, cnt, 1'b0, dev, model,
                8'h0, 1'b1, k, 4'hF - {1'b0, k}};
    endfunction

    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk_i);
        #1 rst_n_i = 1'b1;
        // Reset values and unmapped places
        for (int b = 8; b < 12; b++) begin
            rd({b[3:0], 2'b01}, 64'h0, 1'b0);
            rd({b[3:0], 2'b11}, 64'h0, 1'b0);
        end
        rd(6'h3C, 64'h0, 1'b0);
        rd(6'h1D, 64'h0, 1'b1);
        rd(6'h31, 64'h0, 1'b1);
        wr(6'h22, 64'hFFFF_FFFF_FFFF_FFFF);
        chk({63'h0, msr_fault_o}, 64'h1);
        // Reserved bits stay zero in every bank
        for (int b = 0; b < 4; b++) begin
            wr({2'b10, b[1:0], 2'b01}, 64'hFFFF_FFFF_FFFF_FFFF);
            rd({2'b10, b[1:0], 2'b01}, 64'hFFFF_FFDF_FFFF_FFFF, 1'b0);
            wr({2'b10, b[1:0], 2'b11}, 64'hFFFF_FFFF_FFFF_FFFF);
            rd({2'b10, b[1:0], 2'b11}, 64'hC0FF_FFFF_FFFF_FFFF, 1'b0);
            wr({2'b10, b[1:0], 2'b01}, 64'h0);
            wr({2'b10, b[1:0], 2'b11}, 64'h0);
        end
        // Every code with extra logging off, spread over the banks
        for (int k = 0; k < 7; k++) begin
            err(k[1:0], k[2:0], 1'b0);
            chk({60'h0, bank_valid_o}, 64'h1 << k[1:0]);
            rd({2'b10, k[1:0], 2'b01},
               st_exp(k[2:0], {14'h0, k inside {3, 5}}, 1'b0, 5'h0),
               1'b0);
            mi = {50'h0, (k == 1 || k == 2) ? 5'h13 : 5'h0, 9'h1A5};
            rd({2'b10, k[1:0], 2'b11}, mi, 1'b0);
            wr({2'b10, k[1:0], 2'b01}, 64'h0);
            wr({2'b10, k[1:0], 2'b11}, 64'h0);
        end
        // Second corrected error overflows and counts; uncorrected displaces
        err(2'h0, 3'h3, 1'b0);
        err(2'h0, 3'h3, 1'b0);
        rd(6'h21, st_exp(3'h3, 15'h2, 1'b1, 5'h0), 1'b0);
        err(2'h0, 3'h4, 1'b0);
        rd(6'h21, st_exp(3'h4, 15'h2, 1'b1, 5'h0), 1'b0);
        // Extra logging: first device, then second device
        wr(6'h3C, 64'hFFFF_FFFF_FFFF_FFFF);
        rd(6'h3C, 64'h2, 1'b0);
        chk({63'h0, extra_logging_o}, 64'h1);
        err_addr_info_i = 9'h05A;
        err_dev1_id_i = 5'h1C;
        err(2'h1, 3'h7, 1'b0);
        rd(6'h25, st_exp(3'h7, 15'h1, 1'b0, 5'h1C), 1'b0);
        mi = {2'b01, 6'h0, 5'h0, 5'h07, 16'h0, 16'hA5C3, 5'h0, 9'h05A};
        rd(6'h27, mi, 1'b0);
        err(2'h1, 3'h7, 1'b1);
        mi = {2'b11, 6'h0, 5'h19, 5'h07, 16'h3C5A, 16'hA5C3, 5'h16,
              9'h05A};
        rd(6'h27, mi, 1'b0);
        wr(6'h3C, 64'h0);
        chk({63'h0, extra_logging_o}, 64'h0);
        finish_test();
    end

    // Watchdog, far beyond the some 176 cycles the tests take
    initial begin
        #100_000;
        errors++;
        finish_test();
    end
endmodule
`default_nettype wire
